// File: sbot_pkg.sv
// Package of register map, field layout and timing constants for the sink blink timer
package sbot_pkg;

  // Register offsets
  localparam logic [7:0] SBOT_SINK_ENABLE_ADDR = 8'h10;
  localparam logic [7:0] SBOT_ON_TIME_ADDR = 8'h11;
  localparam logic [7:0] SBOT_OFF_TIME_ADDR = 8'h12;

  // Field positions and reset values
  localparam int SBOT_NUM_SINKS = 4;
  localparam int SBOT_ON_SELECT_LSB = 6;
  localparam int SBOT_SELECT_WIDTH = 2;
  localparam logic [3:0] SBOT_ENABLE_RESET = 4'h0;
  localparam logic [1:0] SBOT_ON_SELECT_RESET = 2'h0;
  localparam logic [7:0] SBOT_OFF_TIME_RESET = 8'h00;
  localparam logic [1:0] SBOT_OFF_DISABLED = 2'h0;

  // Time base: one tick every 0.1 s
  localparam int SBOT_CLOCK_PERIOD_NS = 4;
  localparam int SBOT_TICK_TIME_NS = 100000000;
  localparam int SBOT_TICK_CYCLES = SBOT_TICK_TIME_NS / SBOT_CLOCK_PERIOD_NS;
  localparam int SBOT_TICK_TIME_MS = 100;
  localparam int SBOT_TICK_COUNT_WIDTH = 25;
  localparam int SBOT_PHASE_COUNT_WIDTH = 5;

  // Phase durations in ms, indexed by the 2-bit selector
  localparam int SBOT_ON_MS_0 = 200;
  localparam int SBOT_ON_MS_1 = 600;
  localparam int SBOT_ON_MS_2 = 800;
  localparam int SBOT_ON_MS_3 = 1200;
  localparam int SBOT_OFF_MS_1 = 600;
  localparam int SBOT_OFF_MS_2 = 1200;
  localparam int SBOT_OFF_MS_3 = 1800;

  // Same durations as tick counts
  localparam logic [3:0][4:0] SBOT_ON_TICKS = {
    5'(SBOT_ON_MS_3 / SBOT_TICK_TIME_MS), 5'(SBOT_ON_MS_2 / SBOT_TICK_TIME_MS),
    5'(SBOT_ON_MS_1 / SBOT_TICK_TIME_MS), 5'(SBOT_ON_MS_0 / SBOT_TICK_TIME_MS)};
  localparam logic [3:0][4:0] SBOT_OFF_TICKS = {
    5'(SBOT_OFF_MS_3 / SBOT_TICK_TIME_MS), 5'(SBOT_OFF_MS_2 / SBOT_TICK_TIME_MS),
    5'(SBOT_OFF_MS_1 / SBOT_TICK_TIME_MS), 5'h00};

  // Blink phase of one sink
  typedef enum logic {
    SBOT_PHASE_ON = 1'b0,
    SBOT_PHASE_OFF = 1'b1
  } sbot_phase_type;

endpackage

// File: sbot_sink_blink_off_timer.sv
// Blink on/off timing for current sinks 1 to 4 with their control registers
//
// Functional notes
// (RL1) Sink 4 off select in bits 7:6 of 0x12
// (RL2) Sink 3 off select in bits 5:4
// (RL3) Sink 2 off select in bits 3:2
// (RL4) Sink 1 off select in bits 1:0
// (RL5) Off select: none, 0.6, 1.2, 1.8 s
// (RL6) Off disabled keeps sink on while enabled
// (RL7) Nonzero off select: alternate off and on phases
// (RL8) Enabled with select 00 conducts continuously
// (RL9) Shared on select 0x11[7:6]: 0.2/0.6/0.8/1.2 s
// (RL10) On phase lasts on time, then off
// (RL11) Enables in 0x10 bits 0 to 3
// (RL12) Clearing enable stops sink, restarts phase
// (RL13) Durations counted in 0.1 s ticks
`timescale 1ns/10ps

module sbot_sink_blink_off_timer #(
  parameter int unsigned TICK_CYCLES = sbot_pkg::SBOT_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  output logic [3:0] sinkDrive
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [3:0] sinkEnable;
  logic [1:0] sharedOnTimeSelect;
  logic [7:0] sinkBlinkOffTimeLow;
  wire hitEnable = regAddr == sbot_pkg::SBOT_SINK_ENABLE_ADDR;
  wire hitOnTime = regAddr == sbot_pkg::SBOT_ON_TIME_ADDR;
  wire hitOffTime = regAddr == sbot_pkg::SBOT_OFF_TIME_ADDR;
  logic [7:0] readMux;

  // Read decode; unused bits and unmapped offsets read zero
  always_comb begin
    if (hitEnable) begin
      readMux = {4'h0, sinkEnable};
    end else if (hitOnTime) begin
      readMux = {sharedOnTimeSelect, 6'h00};
    end else if (hitOffTime) begin
      readMux = sinkBlinkOffTimeLow;
    end else begin
      readMux = 8'h00;
    end
  end

  // Register writes
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sinkEnable <= sbot_pkg::SBOT_ENABLE_RESET;
      sharedOnTimeSelect <= sbot_pkg::SBOT_ON_SELECT_RESET;
      sinkBlinkOffTimeLow <= sbot_pkg::SBOT_OFF_TIME_RESET;
    end else if (regWrite) begin
      if (hitEnable) begin
        sinkEnable <= regWriteData[3:0]; // [RL11]
      end
      if (hitOnTime) begin
        sharedOnTimeSelect <= regWriteData[sbot_pkg::SBOT_ON_SELECT_LSB +: 2]; // [RL9]
      end
      if (hitOffTime) begin
        sinkBlinkOffTimeLow <= regWriteData; // [RL1] [RL2] [RL3] [RL4]
      end
    end
  end

  // Read data held until the next read strobe
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      regReadData <= 8'h00;
    end else if (regRead) begin
      regReadData <= readMux;
    end
  end

  a_off_field_write: assert property (@(posedge clock) disable iff (!rst_b) // [RL1]
    regWrite && regAddr == sbot_pkg::SBOT_OFF_TIME_ADDR
    |=> sinkBlinkOffTimeLow == $past(regWriteData))
    else $error("off time register did not take the written byte");

  a_on_field_write: assert property (@(posedge clock) disable iff (!rst_b) // [RL9]
    regWrite && hitOnTime
    |=> sharedOnTimeSelect == $past(regWriteData[sbot_pkg::SBOT_ON_SELECT_LSB +: 2]))
    else $error("on time select did not take bits 7 and 6 of the written byte");

  a_enable_write: assert property (@(posedge clock) disable iff (!rst_b) // [RL11]
    regWrite && hitEnable |=> sinkEnable == $past(regWriteData[3:0]))
    else $error("sink enables did not take the low nibble of the written byte");

  // Read-back; a read sees the value held before any write in the same cycle
  a_enable_readback: assert property (@(posedge clock) disable iff (!rst_b) // [RL11]
    regRead && hitEnable |=> regReadData == {4'h0, $past(sinkEnable)})
    else $error("enable register read-back differs from stored enables");

  a_on_readback: assert property (@(posedge clock) disable iff (!rst_b) // [RL9]
    regRead && hitOnTime |=> regReadData == {$past(sharedOnTimeSelect), 6'h00})
    else $error("on time register read-back differs from stored select");

  a_off_readback: assert property (@(posedge clock) disable iff (!rst_b) // [RL1]
    regRead && hitOffTime |=> regReadData == $past(sinkBlinkOffTimeLow))
    else $error("off time register read-back differs from stored byte");

  ////////////////////////////////////////////////////////////////////////////////
  // Shared time base

  logic [24:0] tickCount;
  logic tick;
  wire tickWrap = tickCount == 25'(TICK_CYCLES - 1);

  // Free running, so a phase's first tick may come early by under 0.1 s
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tickCount <= 25'h0000000;
      tick <= 1'b0;
    end else begin
      tickCount <= tickWrap ? 25'h0000000 : tickCount + 25'h0000001; // [RL13]
      tick <= tickWrap;
    end
  end

  a_tick_single: assert property (@(posedge clock) disable iff (!rst_b) // [RL13]
    tick && TICK_CYCLES > 1 |=> !tick)
    else $error("time base tick lasted more than one cycle");

  // Tick comes exactly at the wrap, so every phase after the first is a whole number of ticks
  a_tick_period: assert property (@(posedge clock) disable iff (!rst_b) // [RL13]
    tickWrap |=> tick && tickCount == 25'h0000000)
    else $error("time base did not wrap and tick together");

  a_tick_only_wrap: assert property (@(posedge clock) disable iff (!rst_b) // [RL13]
    !tickWrap |=> !tick)
    else $error("time base ticked away from its wrap point");

  ////////////////////////////////////////////////////////////////////////////////
  // Per-sink blink sequencer

  // Shared on length; a select change acts on the running count, and a count
  // already past a shorter length runs on to the 5-bit wrap, so change it between phases
  wire [4:0] onTicks = sbot_pkg::SBOT_ON_TICKS[sharedOnTimeSelect]; // [RL9]

  genvar s;
  generate
    for (s = 0; s < sbot_pkg::SBOT_NUM_SINKS; s++) begin : gSink
      sbot_pkg::sbot_phase_type phase;
      sbot_pkg::sbot_phase_type next_phase;
      logic [4:0] phaseCount;
      logic [4:0] next_phaseCount;
      wire [1:0] offSelect = sinkBlinkOffTimeLow[2 * s +: 2]; // [RL1] [RL2] [RL3] [RL4]
      wire blinking = sinkEnable[s] && offSelect != sbot_pkg::SBOT_OFF_DISABLED;
      wire [4:0] offTicks = sbot_pkg::SBOT_OFF_TICKS[offSelect]; // [RL5]
      wire [4:0] phaseLength = (phase == sbot_pkg::SBOT_PHASE_ON) ? onTicks : offTicks;
      wire phaseDone = tick && phaseCount == phaseLength - 5'h01;

      // Phase stepping; held at a fresh on phase while not blinking
      always_comb begin
        next_phase = phase;
        next_phaseCount = phaseCount;
        if (!blinking) begin
          next_phase = sbot_pkg::SBOT_PHASE_ON; // [RL12]
          next_phaseCount = 5'h00;
        end else if (phaseDone) begin
          next_phase = (phase == sbot_pkg::SBOT_PHASE_ON) ? sbot_pkg::SBOT_PHASE_OFF
                                                          : sbot_pkg::SBOT_PHASE_ON; // [RL7]
          next_phaseCount = 5'h00;
        end else if (tick) begin
          next_phaseCount = phaseCount + 5'h01; // [RL13]
        end
      end

      // Phase state and sink drive
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          phase <= sbot_pkg::SBOT_PHASE_ON;
          phaseCount <= 5'h00;
          sinkDrive[s] <= 1'b0;
        end else begin
          phase <= next_phase;
          phaseCount <= next_phaseCount;
          // Steady when select is 00, else follows phase [RL6] [RL8] [RL10]
          sinkDrive[s] <= sinkEnable[s] &&
            (offSelect == sbot_pkg::SBOT_OFF_DISABLED || phase == sbot_pkg::SBOT_PHASE_ON);
        end
      end

      a_disable_stops: assert property (@(posedge clock) disable iff (!rst_b) // [RL12]
        !sinkEnable[s] |=> !sinkDrive[s] && phase == sbot_pkg::SBOT_PHASE_ON
          && phaseCount == 5'h00)
        else $error("disabled sink still driven or phase not restarted");

      a_steady_on: assert property (@(posedge clock) disable iff (!rst_b) // [RL8]
        sinkEnable[s] && offSelect == 2'h0 |=> sinkDrive[s])
        else $error("enabled sink with off select 00 not driven");

      // Steady sinks keep their sequencer parked, so a later nonzero select starts on
      a_steady_parked: assert property (@(posedge clock) disable iff (!rst_b) // [RL6]
        sinkEnable[s] && offSelect == sbot_pkg::SBOT_OFF_DISABLED
        |=> phase == sbot_pkg::SBOT_PHASE_ON && phaseCount == 5'h00)
        else $error("steady sink left its sequencer running");

      a_blink_drive: assert property (@(posedge clock) disable iff (!rst_b) // [RL10]
        blinking |=> sinkDrive[s] == ($past(phase) == sbot_pkg::SBOT_PHASE_ON))
        else $error("blinking sink drive does not follow its phase");

      a_on_to_off: assert property (@(posedge clock) disable iff (!rst_b) // [RL9]
        blinking && phase == sbot_pkg::SBOT_PHASE_ON && tick && phaseCount == onTicks - 5'h01
        |=> phase == sbot_pkg::SBOT_PHASE_OFF && phaseCount == 5'h00)
        else $error("on phase did not end after its selected length");

      a_off_to_on: assert property (@(posedge clock) disable iff (!rst_b) // [RL5]
        blinking && phase == sbot_pkg::SBOT_PHASE_OFF && tick
          && phaseCount == offTicks - 5'h01
        |=> phase == sbot_pkg::SBOT_PHASE_ON ##1 sinkDrive[s] || !$past(blinking))
        else $error("off phase did not end after its selected length");

      a_count_holds: assert property (@(posedge clock) disable iff (!rst_b) // [RL13]
        blinking && !tick |=> $stable(phaseCount) && $stable(phase))
        else $error("phase advanced without a time base tick");
    end
  endgenerate

endmodule

// File: tb_top.sv
// Self-checking testbench for the sink blink off timer
`timescale 1ns/10ps

module tb_top;
  localparam int T = 10;
  localparam int LIMIT = 60000;
  localparam int ON_T[4] = '{2, 6, 8, 12};
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWriteData = 8'h00;
  logic [7:0] regReadData;
  logic [3:0] sinkDrive;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  // Address, written byte, expected read back; unmapped and unstored bits read 0
  logic [7:0] rows [5][3] = '{'{8'h10, 8'hff, 8'h0f}, '{8'h11, 8'hff, 8'hc0},
    '{8'h12, 8'ha5, 8'ha5}, '{8'h20, 8'hff, 8'h00}, '{8'h12, 8'h00, 8'h00}};

  ////////////////////////////////////////////////////////////////
  // Short tick so a full blink cycle takes hundreds of cycles, not millions
  sbot_sink_blink_off_timer #(.TICK_CYCLES(T)) uut (
    .clock(clock), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
    .sinkDrive(sinkDrive));

  always #2 clock = ~clock;

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Strobes are one cycle wide, set and dropped on falling edges; the leading wait
  // keeps back-to-back calls from dropping and raising a strobe in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regWriteData = d;
    regWrite = 1'b1;
    @(negedge clock) regWrite = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clock) regRead = 1'b0;
    chk(32'(regReadData), 32'(exp));
  endtask

  // Skip the running phase, then count one whole phase at level lvl
  task automatic measure(input int idx, input logic lvl, input int exp);
    int n;
    n = 0;
    while (sinkDrive[idx] === lvl) @(negedge clock);
    while (sinkDrive[idx] !== lvl) @(negedge clock);
    while (sinkDrive[idx] === lvl) begin
      n++;
      @(negedge clock);
    end
    chk(32'(n), 32'(exp));
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    // Register rows
    for (int i = 0; i < 5; i++) begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][0], rows[i][2]);
    end
    // Sink 1 steady, sinks 2..4 off selects 1..3, every on select
    wr(8'h12, 8'he4);
    wr(8'h10, 8'h0f);
    for (int k = 0; k < 4; k++) begin
      wr(8'h11, 8'(k << 6));
      for (int s = 1; s < 4; s++) begin
        measure(s, 1'b0, s * 6 * T);
        measure(s, 1'b1, ON_T[k] * T);
      end
      chk(32'(sinkDrive[0]), 32'h1);
    end
    // Clearing enables stops all sinks one cycle after the register clears
    wr(8'h10, 8'h00);
    @(negedge clock);
    chk(32'(sinkDrive), 32'h0);
    // Re-enable starts with the on phase
    wr(8'h10, 8'h08);
    @(negedge clock);
    chk(32'(sinkDrive), 32'h8);
    // Mid-run reset brings every register back to zero
    rst_b = 1'b0;
    @(negedge clock);
    chk(32'(sinkDrive), 32'h0);
    rst_b = 1'b1;
    @(negedge clock);
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h00);
    rd(8'h12, 8'h00);
    final_report();
  end
endmodule
